//--- design/rss_pkg.sv
// Package: register map, field positions and constants of the source selector
package rss_pkg;
  localparam int NUM_SRC  = 14;          // Input ports 1..14
  localparam int SEL_W    = 4;           // Width of an input number
  localparam int PRIO_W   = 4;           // Width of one priority field
  // Printed offsets are indexes; byte address is four times the index
  localparam logic [7:0] IDX_INT_FLAGS   = 8'h06;
  localparam logic [7:0] IDX_OP_STATE    = 8'h09;
  localparam logic [7:0] IDX_SRC_OVR     = 8'h33;
  localparam logic [7:0] IDX_TOL_A       = 8'h41;
  localparam logic [7:0] IDX_TOL_B       = 8'h42;
  localparam logic [7:0] IDX_MON_CTRL    = 8'h48;
  localparam logic [7:0] IDX_PRIO_BASE   = 8'h18;  // Seven priority words
  localparam logic [7:0] IDX_ALARM_LIM   = 8'h50;  // Soft/hard alarm limits
  localparam logic [7:0] IDX_LOCK_LIM    = 8'h51;  // DPLL lock limit
  localparam logic [7:0] IDX_SEL_CTRL    = 8'h52;  // Revertive / lost action
  localparam logic [7:0] IDX_SEL_STAT    = 8'h53;  // Selected input
  localparam logic [7:0] IDX_VALID_LO    = 8'h54;  // Validity flags 1..8
  localparam logic [7:0] IDX_VALID_HI    = 8'h55;  // Validity flags 9..14
  localparam int PRIO_REGS = 7;
  // Field positions
  localparam int INT_LOST_BIT   = 6;   // Selected reference lost
  localparam int MON_EXT_BIT    = 4;   // External switch init
  localparam int MON_QUICK_BIT  = 5;   // Quick-loss switch enable
  localparam int MON_SCAN_BIT   = 6;   // Lost flag on scan output
  localparam int CTL_REVERT_BIT = 0;   // Revertive mode
  localparam int CTL_LSW_BIT    = 1;   // Lost causes switch
  localparam int CTL_LINT_BIT   = 2;   // Lost raises interrupt flag
  localparam logic [2:0] ST_LOCKED = 3'h2;  // Operating state: locked
  localparam logic [2:0] ST_FREE   = 3'h1;  // Operating state: free-run
  // Limit codes: alarm limits in steps of about 0.81 ppm, lock limit in 0.4 ppm steps
  localparam logic [7:0] RST_SOFT_LIM = 8'h0e; // 11.43 ppm step code
  localparam logic [7:0] RST_HARD_LIM = 8'h13; // 15.24 ppm step code
  localparam real ALARM_STEP_PPM = 0.81;       // About 3.8/4.7 step
  localparam logic [7:0] LIM_MIN  = 8'h05;     // 3.8 ppm code
  localparam logic [7:0] LIM_MAX  = 8'h4b;     // 61 ppm code
  localparam logic [7:0] LOCK_9P2 = 8'h17;     // 9.2 ppm in 0.4 ppm steps
  localparam logic [7:0] LOCK_80  = 8'hc8;     // 80 ppm in 0.4 ppm steps
  localparam logic [7:0] RST_OVR  = 8'h0f;     // Automatic mode
  localparam logic [7:0] RST_PRIO = 8'h00;     // Priority reset fill
  localparam logic [3:0] NIB_ZERO = 4'h0;
  localparam logic [3:0] NIB_ONES = 4'hf;
  localparam logic [3:0] IN3 = 4'h3;
  localparam logic [3:0] IN4 = 4'h4;
  localparam logic [3:0] IN5 = 4'h5;
  localparam logic [3:0] IN6 = 4'h6;
  localparam logic [3:0] IN11 = 4'hb;
  localparam real CLK_MHZ    = 250.0;
  localparam real STRAP_MS   = 251.0;
  localparam int  STRAP_CYC  = int'(STRAP_MS * CLK_MHZ * 1000.0);
  localparam logic [1:0] RESP_OK  = 2'b00;
  localparam logic [1:0] RESP_ERR = 2'b10;
endpackage

//--- design/rss_top.sv
// Reference source selector with AXI4-Lite register slave
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module rss_top #(
  parameter int N          = rss_pkg::NUM_SRC,   // Number of inputs
  parameter int STRAP_CYCS = rss_pkg::STRAP_CYC  // Strap hold time
) (
  input  wire logic        clock_i,        // System clock 250 MHz
  input  wire logic        rstn_i,         // Async reset, active low
  input  wire logic [N-1:0] src_valid_i,   // Monitor validity per input
  input  wire logic [N-1:0] src_act_i,     // Fast activity per input
  input  wire logic        external_switch_select_i, // Switch pin
  input  wire logic [31:0] s_axi_awaddr,   // Write address
  input  wire logic        s_axi_awvalid,  // Write address valid
  output logic             s_axi_awready,  // Write address ready
  input  wire logic [31:0] s_axi_wdata,    // Write data
  input  wire logic [3:0]  s_axi_wstrb,    // Write strobes
  input  wire logic        s_axi_wvalid,   // Write data valid
  output logic             s_axi_wready,   // Write data ready
  output logic [1:0]       s_axi_bresp,    // Write response
  output logic             s_axi_bvalid,   // Write response valid
  input  wire logic        s_axi_bready,   // Write response ready
  input  wire logic [31:0] s_axi_araddr,   // Read address
  input  wire logic        s_axi_arvalid,  // Read address valid
  output logic             s_axi_arready,  // Read address ready
  output logic [31:0]      s_axi_rdata,    // Read data
  output logic [1:0]       s_axi_rresp,    // Read response
  output logic             s_axi_rvalid,   // Read data valid
  input  wire logic        s_axi_rready,   // Read data ready
  output logic [3:0]       sel_src_o,      // Selected input, 0 none
  output logic             sel_valid_o,    // A source is selected
  output logic             scan_out_o,     // Scan output value
  output logic             scan_oe_o,      // Scan output lost-flag mode
  output logic [7:0]       lock_limit_o,   // DPLL lock limit code
  output logic             holdover_o,     // DPLL frozen
  output logic             monitors_off_o  // Monitoring disabled
);
  // Every check runs on the system clock and sleeps during reset
  default clocking cb_sys @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  // Register storage
  logic [7:0] ovr_q;                      // Source override
  logic [7:0] mon_q;                      // Monitor control
  logic [7:0] tol_a_q, tol_b_q;           // Input tolerances
  logic [7:0] soft_q, hard_q;             // Alarm limit codes
  logic [7:0] lock_q;                     // DPLL lock limit
  logic [2:0] ctl_q;                      // Selection control
  localparam int PRIO_REGS_L = rss_pkg::PRIO_REGS;
  logic [7:0] prio_q [PRIO_REGS_L];       // Priority table
  logic       lost_q;                     // Lost flag
  logic [N-1:0] vflag_q;                  // Newly valid flags
  // Synchronised pins
  logic [N-1:0] val_m, val_s, act_m, act_s;
  logic         pin_m, pin_s;
  // Synchronisers; first stage read only by second
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      val_m <= '0;
      val_s <= '0;
      act_m <= '0;
      act_s <= '0;
      pin_m <= 1'b0;
      pin_s <= 1'b0;
    end else begin
      val_m <= src_valid_i;
      val_s <= val_m;
      act_m <= src_act_i;
      act_s <= act_m;
      pin_m <= external_switch_select_i;
      pin_s <= pin_m;
    end
  end

  // Strap capture: pin must stay high for the hold window after reset
  logic [31:0] strap_cnt_q;               // Cycles since release
  logic        strap_busy_q;              // Window still open
  logic        strap_ok_q;                // Pin held high so far
  logic        strap_done_q;              // Strap init taken
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      strap_cnt_q  <= '0;
      strap_busy_q <= 1'b1;
      strap_ok_q   <= 1'b1;
      strap_done_q <= 1'b0;
    end else if (strap_busy_q) begin
      // Synchroniser still shows its reset value for two edges
      strap_ok_q <= strap_ok_q & (pin_s | (strap_cnt_q < 32'h2));
      if (strap_cnt_q == 32'(STRAP_CYCS - 1)) begin
        strap_busy_q <= 1'b0;
        strap_done_q <= strap_ok_q & pin_s;
      end else begin
        strap_cnt_q <= strap_cnt_q + 32'h1;
      end
    end
  end
  logic ext_on;                           // External mode active
  assign ext_on = strap_done_q | mon_q[rss_pkg::MON_EXT_BIT];

  // Per-input priority and candidacy
  logic [3:0]   prio [N];
  logic [N-1:0] cand;
  logic         qsw_on;                   // Quick loss drops a source
  assign qsw_on = mon_q[rss_pkg::MON_QUICK_BIT] & ctl_q[rss_pkg::CTL_LSW_BIT];
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_cand
      // Two nibbles per priority word, input 1 in word 0 low nibble
      assign prio[g] = prio_q[g/2][4*(g%2) +: 4];
      // Input 11 may carry the master's timing clock; it competes by
      // priority like any other. A silent input drops out so that the
      // quick switch lands on the next source instead of bouncing back
      assign cand[g] = val_s[g] & (prio[g] != rss_pkg::NIB_ZERO) &
                       (act_s[g] | !qsw_on);
    end
  endgenerate

  // FIFO age stamps: smaller age joined the equal-priority group earlier
  logic [7:0] age_q [N];
  logic [7:0] age_ctr_q;                  // Join order counter
  logic [N-1:0] cand_q;                   // Previous candidacy
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      age_ctr_q <= '0;
      cand_q    <= '0;
    end else begin
      cand_q <= cand;
      if (|(cand & ~cand_q)) age_ctr_q <= age_ctr_q + 8'h1;
    end
  end
  generate
    for (g = 0; g < N; g++) begin : g_age
      // New or restored source joins at the back of its group
      always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) age_q[g] <= 8'(g);
        else if (cand[g] && !cand_q[g]) age_q[g] <= age_ctr_q + 8'(N);
      end
    end
  endgenerate

  // Best candidate: lowest priority value, then oldest join
  logic [3:0] best;                       // Best input number, 0 none
  logic [3:0] best_p;
  logic [7:0] best_a;
  always_comb begin
    best   = rss_pkg::NIB_ZERO;
    best_p = rss_pkg::NIB_ONES;
    best_a = '1;
    for (int i = 0; i < N; i++) begin
      if (cand[i] && (best == rss_pkg::NIB_ZERO || prio[i] < best_p ||
          (prio[i] == best_p && age_q[i] < best_a))) begin
        best   = 4'(i + 1);
        best_p = prio[i];
        best_a = age_q[i];
      end
    end
  end

  // Selection process
  logic [3:0] sel_q;
  logic [3:0] ovr_n, ext_pick, cur_p;
  logic       cur_ok, cur_dead;
  assign ovr_n = ovr_q[3:0];
  assign ext_pick = pin_s ?
    ((prio[2] == rss_pkg::NIB_ZERO) ? rss_pkg::IN5 : rss_pkg::IN3) :
    ((prio[3] == rss_pkg::NIB_ZERO) ? rss_pkg::IN6 : rss_pkg::IN4);
  assign cur_ok   = (sel_q != 0) && cand[sel_q - 4'h1];
  assign cur_p    = (sel_q != 0) ? prio[sel_q - 4'h1] : rss_pkg::NIB_ONES;
  // Quick loss: activity gone on the selected input
  assign cur_dead = (sel_q != 0) && !act_s[sel_q - 4'h1];
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sel_q <= rss_pkg::NIB_ZERO;
    end else if (ext_on) begin
      sel_q <= ext_pick;
    end else if (ovr_n != rss_pkg::NIB_ZERO && ovr_n != rss_pkg::NIB_ONES) begin
      sel_q <= ovr_n;
    end else if (!cur_ok || (cur_dead && mon_q[rss_pkg::MON_QUICK_BIT]
                 && ctl_q[rss_pkg::CTL_LSW_BIT])) begin
      sel_q <= (best == sel_q) ? rss_pkg::NIB_ZERO : best;
    end else if (ctl_q[rss_pkg::CTL_REVERT_BIT] && best != 0 &&
                 best_p < cur_p) begin
      sel_q <= best;
    end
  end

  // Newly valid flags, set wins over software clear
  logic wr_go;
  logic [7:0] wr_idx;
  logic [31:0] wd_q;
  generate
    for (g = 0; g < N; g++) begin : g_vf
      always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) vflag_q[g] <= 1'b0;
        else if (cand[g] && !cand_q[g]) vflag_q[g] <= 1'b1;
        else if (wr_go && wr_idx == (g < 8 ? rss_pkg::IDX_VALID_LO :
                 rss_pkg::IDX_VALID_HI) && wd_q[g%8]) vflag_q[g] <= 1'b0;
      end
    end
  endgenerate

  // Lost flag: sticky, cleared by write one to status
  logic lost_ev;
  assign lost_ev = !ext_on && cur_dead && ctl_q[rss_pkg::CTL_LINT_BIT];
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) lost_q <= 1'b0;
    else if (lost_ev) lost_q <= 1'b1;
    else if (wr_go && wr_idx == rss_pkg::IDX_INT_FLAGS &&
             wd_q[rss_pkg::INT_LOST_BIT]) lost_q <= 1'b0;
  end

  // AXI4-Lite write channel: take address and data in any order
  logic aw_h_q, w_h_q;
  logic [7:0] aw_idx_q;
  assign wr_go  = aw_h_q && w_h_q && !s_axi_bvalid;
  assign wr_idx = aw_idx_q;
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      aw_h_q <= 1'b0;
      w_h_q  <= 1'b0;
      aw_idx_q <= '0;
      wd_q   <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= rss_pkg::RESP_OK;
    end else begin
      s_axi_awready <= !aw_h_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_h_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_h_q   <= 1'b1;
        aw_idx_q <= s_axi_awaddr[9:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_h_q <= 1'b1;
        wd_q  <= s_axi_wdata;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= rss_pkg::RESP_OK;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_h_q <= 1'b0;
        w_h_q  <= 1'b0;
      end
    end
  end

  // Register writes; strobe of lane 0 carries all 8-bit fields
  logic wr_ok;
  assign wr_ok = wr_go && s_axi_wstrb_q;
  logic s_axi_wstrb_q;
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) s_axi_wstrb_q <= 1'b0;
    else if (s_axi_wvalid && s_axi_wready) s_axi_wstrb_q <= s_axi_wstrb[0];
  end
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ovr_q  <= rss_pkg::RST_OVR;
      mon_q  <= '0;
      soft_q <= rss_pkg::RST_SOFT_LIM;
      hard_q <= rss_pkg::RST_HARD_LIM;
      lock_q <= rss_pkg::LOCK_9P2;
      tol_a_q <= rss_pkg::LOCK_9P2;
      tol_b_q <= rss_pkg::LOCK_9P2;
      ctl_q  <= 3'h6;
      for (int i = 0; i < PRIO_REGS_L; i++) prio_q[i] <= rss_pkg::RST_PRIO;
    end else begin
      if (strap_busy_q && strap_cnt_q == 32'(STRAP_CYCS - 1) &&
          strap_ok_q && pin_s) begin
        tol_a_q <= rss_pkg::LOCK_80;
        tol_b_q <= rss_pkg::LOCK_80;
      end
      if (wr_ok) begin
        case (wr_idx)
          rss_pkg::IDX_SRC_OVR:  ovr_q  <= wd_q[7:0];
          rss_pkg::IDX_MON_CTRL: mon_q  <= wd_q[7:0];
          rss_pkg::IDX_TOL_A:    tol_a_q <= wd_q[7:0];
          rss_pkg::IDX_TOL_B:    tol_b_q <= wd_q[7:0];
          rss_pkg::IDX_ALARM_LIM: begin
            // Clamp both limits into the programmable span
            soft_q <= (wd_q[7:0] < rss_pkg::LIM_MIN) ? rss_pkg::LIM_MIN :
                      (wd_q[7:0] > rss_pkg::LIM_MAX) ? rss_pkg::LIM_MAX :
                      wd_q[7:0];
            hard_q <= (wd_q[15:8] < rss_pkg::LIM_MIN) ? rss_pkg::LIM_MIN :
                      (wd_q[15:8] > rss_pkg::LIM_MAX) ? rss_pkg::LIM_MAX :
                      wd_q[15:8];
          end
          rss_pkg::IDX_LOCK_LIM:
            lock_q <= (wd_q[7:0] > rss_pkg::LOCK_80) ? rss_pkg::LOCK_80 :
                      wd_q[7:0];
          rss_pkg::IDX_SEL_CTRL: ctl_q <= wd_q[2:0];
          default: begin
            for (int i = 0; i < PRIO_REGS_L; i++)
              if (wr_idx == rss_pkg::IDX_PRIO_BASE + 8'(i))
                prio_q[i] <= wd_q[7:0];
          end
        endcase
      end
    end
  end

  // AXI4-Lite read channel, one cycle after address taken
  logic [7:0] rd_v;
  logic [7:0] rd_hi;                      // Second byte of read word
  logic       rd_hit;
  logic [7:0] ridx;
  assign ridx = s_axi_araddr[9:2];
  always_comb begin
    rd_hit = 1'b1;
    rd_v   = '0;
    rd_hi  = '0;
    case (ridx)
      rss_pkg::IDX_INT_FLAGS: rd_v = {1'b0, lost_q, 6'h00};
      rss_pkg::IDX_OP_STATE:  rd_v = {5'h00, (ext_on || sel_q != 0) ?
                                 rss_pkg::ST_LOCKED : rss_pkg::ST_FREE};
      rss_pkg::IDX_SRC_OVR:   rd_v = ovr_q;
      rss_pkg::IDX_TOL_A:     rd_v = tol_a_q;
      rss_pkg::IDX_TOL_B:     rd_v = tol_b_q;
      rss_pkg::IDX_MON_CTRL:  rd_v = mon_q;
      rss_pkg::IDX_ALARM_LIM: begin
        rd_v  = soft_q;
        rd_hi = hard_q;
      end
      rss_pkg::IDX_LOCK_LIM:  rd_v = lock_q;
      rss_pkg::IDX_SEL_CTRL:  rd_v = {5'h00, ctl_q};
      rss_pkg::IDX_SEL_STAT:  rd_v = {4'h0, sel_q};
      rss_pkg::IDX_VALID_LO:  rd_v = vflag_q[7:0];
      rss_pkg::IDX_VALID_HI:  rd_v = {2'b00, vflag_q[13:8]};
      default: begin
        rd_hit = 1'b0;
        for (int i = 0; i < PRIO_REGS_L; i++)
          if (ridx == rss_pkg::IDX_PRIO_BASE + 8'(i)) begin
            rd_hit = 1'b1;
            rd_v   = prio_q[i];
          end
      end
    endcase
  end
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= rss_pkg::RESP_OK;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {16'h0, rd_hi, rd_v};
        s_axi_rresp  <= rd_hit ? rss_pkg::RESP_OK : rss_pkg::RESP_ERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Outputs from flip-flops
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sel_src_o      <= '0;
      sel_valid_o    <= 1'b0;
      scan_out_o     <= 1'b0;
      scan_oe_o      <= 1'b0;
      lock_limit_o   <= rss_pkg::LOCK_9P2;
      holdover_o     <= 1'b0;
      monitors_off_o <= 1'b0;
    end else begin
      sel_src_o      <= sel_q;
      sel_valid_o    <= sel_q != 0;
      scan_out_o     <= lost_q;
      scan_oe_o      <= mon_q[rss_pkg::MON_SCAN_BIT];
      lock_limit_o   <= lock_q;
      holdover_o     <= !ext_on && cur_dead;
      monitors_off_o <= ext_on;
    end
  end

  // Checks
  lost_sticky_a: assert property (
    (lost_q && !(wr_go && wr_idx == rss_pkg::IDX_INT_FLAGS &&
     wd_q[rss_pkg::INT_LOST_BIT])) |=> lost_q)
    else $error("lost flag dropped");
  scan_mirror_a: assert property (
    ##1 scan_out_o == $past(lost_q)) else $error("scan mismatch");
  forced_sel_a: assert property (
    (!ext_on && ovr_n != rss_pkg::NIB_ZERO && ovr_n != rss_pkg::NIB_ONES)
    |=> sel_q == $past(ovr_n)) else $error("forced pick wrong");
  ext_pick_a: assert property (
    ext_on |=> sel_q == $past(ext_pick)) else $error("external pick wrong");
  cand_zero_a: assert property (
    best != 0 |-> prio[best - 4'h1] != 0) else $error("zero prio chosen");
  fail_sw_a: assert property (
    (!ext_on && ovr_n == rss_pkg::NIB_ONES && sel_q != 0 && !cur_ok)
    |=> sel_q != $past(sel_q)) else $error("no switch on fail");
  nonrev_a: assert property (
    (!ext_on && ovr_n == rss_pkg::NIB_ONES && cur_ok && !cur_dead &&
     !ctl_q[rss_pkg::CTL_REVERT_BIT]) |=> sel_q == $past(sel_q))
    else $error("non-revertive switched");
  lock_max_a: assert property (
    lock_q <= rss_pkg::LOCK_80) else $error("lock limit high");
  cov_rev_c: cover property (@(posedge clock_i) disable iff (!rstn_i)
    ctl_q[0] && $changed(sel_q));
  cov_ext_c: cover property (@(posedge clock_i) disable iff (!rstn_i)
    $rose(ext_on));
  cov_lost_c: cover property (@(posedge clock_i) disable iff (!rstn_i)
    $rose(lost_q));
endmodule
`default_nettype wire

//--- dv/rss_src_model.sv
// Partner model: monitor results of the input reference sources
`timescale 1ns/1ps
`default_nettype none
module rss_src_model (
  input  wire logic        clock_i, // System clock
  input  wire logic        rstn_i,  // Async reset, active low
  input  wire logic [13:0] fail_i,  // Inputs the bench disqualifies
  input  wire logic [13:0] quiet_i, // Inputs the bench stops toggling
  output logic      [13:0] valid_o, // Monitor validity, bit0 is input 1
  output logic      [13:0] act_o    // Fast activity per input
);
  // Sources absent in reset; only commanded faults, never spurious ones
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      valid_o <= 14'h0000;
      act_o   <= 14'h0000;
    end else begin
      valid_o <= ~fail_i;
      act_o   <= ~quiet_i;
    end
  end
endmodule
`default_nettype wire

//--- dv/rss_tb_top.sv
// Testbench: register bus, automatic, forced, quick-loss, external modes
`timescale 1ns/1ps
`default_nettype none
module rss_tb_top;
  logic        clock_i, rstn_i, external_switch_select_i;
  logic [13:0] fail, quiet, src_valid_i, src_act_i;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [3:0]  sel_src_o;
  logic [7:0]  lock_limit_o;
  logic        sel_valid_o, scan_out_o, scan_oe_o, holdover_o, monitors_off_o;
  int          error_cnt, comparisons;
  // Short strap window keeps the run brief
  rss_top #(.STRAP_CYCS(16)) u_rss_top (
    .clock_i, .rstn_i, .src_valid_i, .src_act_i, .external_switch_select_i,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'h1), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .sel_src_o, .sel_valid_o, .scan_out_o, .scan_oe_o, .lock_limit_o,
    .holdover_o, .monitors_off_o);
  rss_src_model u_rss_src_model (.clock_i, .rstn_i, .fail_i(fail),
    .quiet_i(quiet), .valid_o(src_valid_i), .act_o(src_act_i));
  // Free-running 250 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Write one register word; address and data released as each is taken
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    s_axi_awaddr <= {22'h0, idx, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, 32'h0);
    @(posedge clock_i);
  endtask
  // Read one word and compare masked data and response
  task automatic rchk(input logic [7:0] idx, input logic [31:0] m, e,
                      input logic [1:0] r);
    s_axi_araddr <= {22'h0, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata & m, e);
    chk({30'h0, s_axi_rresp}, {30'h0, r});
    @(posedge clock_i);
  endtask
  // Bounded wait for the selected input, then compare
  task automatic wsel(input logic [3:0] n);
    for (int i = 0; i < 40 && sel_src_o !== n; i++) @(posedge clock_i);
    chk({28'h0, sel_src_o}, {28'h0, n});
    chk({31'h0, sel_valid_o}, {31'h0, (n != 4'h0)});
  endtask
  task automatic t_reset;
    rchk(8'h33, 32'hff, 32'h0f, 2'b00);
    rchk(8'h50, 32'hffff, 32'h130e, 2'b00);
    rchk(8'h18, 32'hff, 32'h00, 2'b00);
    rchk(8'h7f, 32'hffffffff, 32'h0, 2'b10);
    chk({24'h0, lock_limit_o}, 32'h17);
    wr(8'h51, 8'hff);
    rchk(8'h51, 32'hff, 32'hc8, 2'b00);
    wr(8'h51, 8'h17);
  endtask
  task automatic t_auto;
    wr(8'h18, 8'h13);
    wr(8'h19, 8'h02);
    wsel(4'h2);
    fail <= 14'h0002;
    wsel(4'h3);
    fail <= 14'h0000;
    repeat (20) @(posedge clock_i);
    chk({28'h0, sel_src_o}, 32'h3);
    rchk(8'h54, 32'h02, 32'h02, 2'b00);
    wr(8'h52, 8'h07);
    wsel(4'h2);
    wr(8'h52, 8'h06);
    fail <= 14'h0007;
    wsel(4'h0);
    fail <= 14'h0000;
  endtask
  task automatic t_force;
    wr(8'h33, 8'h05);
    wsel(4'h5);
    wr(8'h33, 8'h00);
    wsel(4'h2);
  endtask
  task automatic t_quick;
    wr(8'h48, 8'h60);
    chk({31'h0, scan_oe_o}, 32'h1);
    quiet <= 14'h0002;
    wsel(4'h3);
    chk({31'h0, holdover_o}, 32'h0);
    rchk(8'h06, 32'h40, 32'h40, 2'b00);
    chk({31'h0, scan_out_o}, 32'h1);
    quiet <= 14'h0000;
    wr(8'h06, 8'h40);
    repeat (4) @(posedge clock_i);
    chk({31'h0, scan_out_o}, 32'h0);
    // Lost only flags, no switch: the silent input just freezes the loop
    wr(8'h52, 8'h04);
    quiet <= 14'h0004;
    repeat (6) @(posedge clock_i);
    chk({31'h0, holdover_o}, 32'h1);
    chk({28'h0, sel_src_o}, 32'h3);
    chk({31'h0, scan_out_o}, 32'h1);
    quiet <= 14'h0000;
  endtask
  task automatic t_ext;
    wr(8'h19, 8'h22);
    wr(8'h48, 8'h10);
    wsel(4'h4);
    chk({31'h0, monitors_off_o}, 32'h1);
    rchk(8'h09, 32'h07, 32'h02, 2'b00);
    external_switch_select_i <= 1'b1;
    wsel(4'h3);
    wr(8'h19, 8'h20);
    wsel(4'h5);
    external_switch_select_i <= 1'b0;
    wr(8'h19, 8'h02);
    wsel(4'h6);
  endtask
  // Reset again with the switch pin high: strap starts external mode
  task automatic t_strap;
    external_switch_select_i <= 1'b1;
    rstn_i <= 1'b0;
    repeat (8) @(posedge clock_i);
    rstn_i <= 1'b1;
    repeat (24) @(posedge clock_i);
    chk({31'h0, monitors_off_o}, 32'h1);
    rchk(8'h41, 32'hff, 32'hc8, 2'b00);
    rchk(8'h42, 32'hff, 32'hc8, 2'b00);
    wsel(4'h5);
  endtask
  task automatic print_verdict;
    if (error_cnt == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Hang guard well beyond the few hundred cycles the tests need
  initial begin
    repeat (30000) @(posedge clock_i);
    error_cnt++;
    print_verdict();
  end
  initial begin
    {rstn_i, external_switch_select_i, fail, quiet} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    repeat (8) @(posedge clock_i);
    rstn_i <= 1'b1;
    @(posedge clock_i);
    t_reset();
    t_auto();
    t_force();
    t_quick();
    t_ext();
    t_strap();
    print_verdict();
  end
endmodule
`default_nettype wire
